// ### hdl/cmr_pkg.sv
package cmr_pkg;
    // =====================================================================
    // Widths
    localparam int DATA_W     = 16;
    localparam int SHIFT_W    = 19;
    localparam int MULT_W     = 33;
    localparam int ACC_W      = 35;
    localparam int OUT_W      = 20;
    localparam int CACC_W     = 20;
    localparam int WORD_W     = 16;
    localparam int FIFO_DEPTH = 16;

    // =====================================================================
    // Output field layout
    localparam int PROD_OUT_LSB = 15;
    localparam int PROD_HI_LSB  = 31;
    localparam int HI_W         = 4;
    localparam int LO_W         = 16;
    localparam int PROD_LOW_W   = 15;
    localparam int CACC_OUT_LSB = 0;

    // =====================================================================
    // Codes
    localparam logic [1:0] SRC_PROD     = 2'h0;
    localparam logic [1:0] SRC_PROD_LOW = 2'h1;
    localparam logic [1:0] SRC_CACC     = 2'h2;
    localparam logic [1:0] TGT_ROUND    = 2'h3;
    localparam logic [1:0] GROWTH_RST   = 2'h0;

    // =====================================================================
    // Rounding control word
    localparam int          RND_CACC_LSB   = 0;
    localparam int          RND_PROD_LSB   = 4;
    localparam int          RND_FLD_W      = 4;
    localparam logic [3:0]  RND_NONE       = 4'h0;
    localparam logic [3:0]  RND_MAX        = 4'hC;
    localparam logic [15:0] ROUND_WORD_RST = 16'h0000;

    typedef struct packed {
        logic [DATA_W-1:0] real_in;
        logic [DATA_W-1:0] imag_in;
        logic              in_en_n;
        logic [1:0]        scale_sel;
        logic              feedback_keep;
        logic [1:0]        src_sel;
        logic              fmt;
        logic              peak_hold_n;
        logic              round_enable_n;
        logic [WORD_W-1:0] cfg_word;
        logic [1:0]        target;
        logic              cs_n;
        logic              wr_n;
    } cmr_pins_t;

    typedef struct packed {
        logic [OUT_W-1:0] real_out;
        logic [OUT_W-1:0] imag_out;
        logic [1:0]       growth;
    } cmr_sample_t;
endpackage

// ### hdl/cmr_top.sv
// Function
// - Real product is cos*real minus sin*imag; imaginary is cos*imag plus sin*real.
// - Input words are captured only on edges with input register enable low.
// - Scale select picks input bits 0-15, 1-16, 2-17 or 3-18.
// - 33-bit real and imaginary products are registered before accumulation.
// - Keep high adds product to accumulator; low stores the product alone.
// - Source select routes product high/low fields or complex accumulator; 11 reserved.
// - Format 0 inverts output top bits; format 1 gives two's complement.
// - Second 20-bit complex accumulator of scaled inputs, shown only when selected.
// - Two-bit growth code gives 0 to 3 bits of growth above unity.
// - With peak hold low the growth register keeps the largest code.
// - Inputs have binary point below top bit; outputs after fifth bit.
// - Rounding only while round enable is low; otherwise outputs are unrounded.
// - Word bits 3-0 round accumulator output, bits 7-4 product output.
// - Real and imaginary of one source are rounded to the same precision.
// - Rounding adds one just below the lowest kept bit.
// - Codes 1-12 keep 20 down to 9 bits; 0 and 13-15 no rounding.
// - Writes with select high, or to other targets, leave the rounding word.
module cmr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign o_ready = (count_q != (AW+1)'(DEPTH));
    assign o_valid = (count_q != '0);
    assign o_data  = mem_q[rd_ptr_q];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) wr_ptr_q <= wr_ptr_q + AW'(1);
            if (pop)  rd_ptr_q <= rd_ptr_q + AW'(1);
            if (push && !pop) count_q <= count_q + (AW+1)'(1);
            else if (pop && !push) count_q <= count_q - (AW+1)'(1);
        end
    end
endmodule // cmr_fifo

module cmr_top import cmr_pkg::*; (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic [DATA_W-1:0] i_real_in,
    input  wire logic [DATA_W-1:0] i_imag_in,
    input  wire logic              i_input_reg_clock_en_n,
    input  wire logic [1:0]        i_input_scale_select,
    input  wire logic              i_feedback_keep,
    input  wire logic [1:0]        i_output_source_select,
    input  wire logic              i_output_number_format,
    input  wire logic              i_peak_hold_n,
    input  wire logic              i_round_enable_n,
    input  wire logic [WORD_W-1:0] i_config_word_bus,
    input  wire logic [1:0]        i_load_target_select,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_write_n,
    input  wire logic [DATA_W-1:0] i_cos,
    input  wire logic [DATA_W-1:0] i_sin,
    input  wire logic              i_out_ready,
    output logic [OUT_W-1:0]       o_real_out,
    output logic [OUT_W-1:0]       o_imag_out,
    output logic [1:0]             o_growth_code,
    output logic                   o_out_valid,
    output logic                   o_sample_stall
);
    // =====================================================================
    // Helpers
    function automatic logic [DATA_W-1:0] scale_pick(input logic [DATA_W-1:0] x,
                                                     input logic [1:0] s);
        logic [SHIFT_W-1:0] e;
        e = {{(SHIFT_W-DATA_W){x[DATA_W-1]}}, x};
        return e[s +: DATA_W];
    endfunction

    function automatic logic [MULT_W-1:0] cmul(input logic signed [DATA_W-1:0] a,
                                               input logic signed [DATA_W-1:0] b,
                                               input logic signed [DATA_W-1:0] c,
                                               input logic signed [DATA_W-1:0] d,
                                               input logic sub);
        logic signed [MULT_W-1:0] p;
        logic signed [MULT_W-1:0] q;
        p = a * b;
        q = c * d;
        return sub ? p - q : p + q;
    endfunction

    // Same code for real and imaginary, so both share one precision
    function automatic logic [OUT_W-1:0] round_field(input logic [ACC_W-1:0] v,
                                                     input int lsb,
                                                     input logic [3:0] code,
                                                     input logic en);
        logic [ACC_W-1:0] t;
        logic [OUT_W-1:0] f;
        logic             act;
        act = en && (code != RND_NONE) && (code <= RND_MAX);
        t = v;
        if (act && (lsb + int'(code) >= 2)) begin
            t = v + (ACC_W'(1) << (lsb + int'(code) - 2));
        end
        f = t[lsb +: OUT_W];
        if (act) begin
            f = f & ~((OUT_W'(1) << (code - 4'h1)) - OUT_W'(1));
        end
        return f;
    endfunction

    function automatic logic [1:0] growth_of(input logic [OUT_W-1:0] v);
        if (&v[19:16] || !(|v[19:16])) return 2'h0;
        else if (&v[19:17] || !(|v[19:17])) return 2'h1;
        else if (v[19] == v[18]) return 2'h2;
        else return 2'h3;
    endfunction

    // =====================================================================
    // Pin synchroniser
    cmr_pins_t pins_raw;
    cmr_pins_t pin_s1_q;
    cmr_pins_t pin_s2_q;
    logic      wr_prev_q;

    assign pins_raw = '{real_in: i_real_in, imag_in: i_imag_in,
                        in_en_n: i_input_reg_clock_en_n, scale_sel: i_input_scale_select,
                        feedback_keep: i_feedback_keep, src_sel: i_output_source_select,
                        fmt: i_output_number_format, peak_hold_n: i_peak_hold_n,
                        round_enable_n: i_round_enable_n, cfg_word: i_config_word_bus,
                        target: i_load_target_select, cs_n: i_chip_select_n,
                        wr_n: i_write_n};

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_s1_q  <= '{in_en_n: 1'b1, round_enable_n: 1'b1, peak_hold_n: 1'b1,
                           cs_n: 1'b1, wr_n: 1'b1, default: '0};
            pin_s2_q  <= '{in_en_n: 1'b1, round_enable_n: 1'b1, peak_hold_n: 1'b1,
                           cs_n: 1'b1, wr_n: 1'b1, default: '0};
            wr_prev_q <= 1'b1;
        end else begin
            pin_s1_q  <= pins_raw;
            pin_s2_q  <= pin_s1_q;
            wr_prev_q <= pin_s2_q.wr_n;
        end
    end

    // =====================================================================
    // Rounding control word
    logic [WORD_W-1:0] round_word_q;
    logic              round_load;

    assign round_load = pin_s2_q.wr_n && !wr_prev_q && !pin_s2_q.cs_n
                        && (pin_s2_q.target == TGT_ROUND);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            round_word_q <= ROUND_WORD_RST;
        end else if (round_load) begin
            round_word_q <= pin_s2_q.cfg_word;
        end
    end

    // =====================================================================
    // Datapath; a full FIFO freezes every stage
    logic                     adv;
    logic [DATA_W-1:0]        in_real_q;
    logic [DATA_W-1:0]        in_imag_q;
    logic [DATA_W-1:0]        sc_real;
    logic [DATA_W-1:0]        sc_imag;
    logic [MULT_W-1:0]        mult_real_q;
    logic [MULT_W-1:0]        mult_imag_q;
    logic [ACC_W-1:0]         acc_real_q;
    logic [ACC_W-1:0]         acc_imag_q;
    logic [CACC_W-1:0]        cacc_real_q;
    logic [CACC_W-1:0]        cacc_imag_q;
    logic                     run_q;

    assign sc_real = scale_pick(in_real_q, pin_s2_q.scale_sel);
    assign sc_imag = scale_pick(in_imag_q, pin_s2_q.scale_sel);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            in_real_q <= '0;
            in_imag_q <= '0;
        end else if (adv && !pin_s2_q.in_en_n) begin
            in_real_q <= pin_s2_q.real_in;
            in_imag_q <= pin_s2_q.imag_in;
        end
    end

    // Inputs Q1.15 times Q1.15 gives product bit 30 at weight one
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            mult_real_q <= '0;
            mult_imag_q <= '0;
        end else if (adv) begin
            mult_real_q <= cmul(i_cos, sc_real, i_sin, sc_imag, 1'b1);
            mult_imag_q <= cmul(i_cos, sc_imag, i_sin, sc_real, 1'b0);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            acc_real_q <= '0;
            acc_imag_q <= '0;
        end else if (adv) begin
            acc_real_q <= (pin_s2_q.feedback_keep ? acc_real_q : '0)
                          + {{(ACC_W-MULT_W){mult_real_q[MULT_W-1]}}, mult_real_q};
            acc_imag_q <= (pin_s2_q.feedback_keep ? acc_imag_q : '0)
                          + {{(ACC_W-MULT_W){mult_imag_q[MULT_W-1]}}, mult_imag_q};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cacc_real_q <= '0;
            cacc_imag_q <= '0;
        end else if (adv) begin
            cacc_real_q <= (pin_s2_q.feedback_keep ? cacc_real_q : '0)
                           + {{(CACC_W-DATA_W){sc_real[DATA_W-1]}}, sc_real};
            cacc_imag_q <= (pin_s2_q.feedback_keep ? cacc_imag_q : '0)
                           + {{(CACC_W-DATA_W){sc_imag[DATA_W-1]}}, sc_imag};
        end
    end

    // =====================================================================
    // Output select, rounding, format, growth
    logic [3:0]        rnd_prod;
    logic [3:0]        rnd_cacc;
    logic              rnd_en;
    logic [ACC_W-1:0]  cacc_real_x;
    logic [ACC_W-1:0]  cacc_imag_x;
    logic [OUT_W-1:0]  sel_real;
    logic [OUT_W-1:0]  sel_imag;
    logic [1:0]        growth_cur;
    logic [1:0]        growth_q;
    logic [1:0]        growth_d;
    cmr_sample_t       push_data;

    assign rnd_prod    = round_word_q[RND_PROD_LSB +: RND_FLD_W];
    assign rnd_cacc    = round_word_q[RND_CACC_LSB +: RND_FLD_W];
    assign rnd_en      = !pin_s2_q.round_enable_n;
    assign cacc_real_x = {{(ACC_W-CACC_W){cacc_real_q[CACC_W-1]}}, cacc_real_q};
    assign cacc_imag_x = {{(ACC_W-CACC_W){cacc_imag_q[CACC_W-1]}}, cacc_imag_q};

    always_comb begin
        unique case (pin_s2_q.src_sel)
            SRC_PROD: begin
                sel_real = round_field(acc_real_q, PROD_OUT_LSB, rnd_prod, rnd_en);
                sel_imag = round_field(acc_imag_q, PROD_OUT_LSB, rnd_prod, rnd_en);
            end
            SRC_PROD_LOW: begin
                sel_real = {acc_real_q[PROD_HI_LSB +: HI_W], 1'b0,
                            acc_real_q[PROD_LOW_W-1:0]};
                sel_imag = {acc_imag_q[PROD_HI_LSB +: HI_W], 1'b0,
                            acc_imag_q[PROD_LOW_W-1:0]};
            end
            SRC_CACC: begin
                sel_real = round_field(cacc_real_x, CACC_OUT_LSB, rnd_cacc, rnd_en);
                sel_imag = round_field(cacc_imag_x, CACC_OUT_LSB, rnd_cacc, rnd_en);
            end
            default: begin
                sel_real = '0;
                sel_imag = '0;
            end
        endcase
    end

    assign growth_cur = (growth_of(sel_real) > growth_of(sel_imag)) ?
                        growth_of(sel_real) : growth_of(sel_imag);
    assign growth_d   = (!pin_s2_q.peak_hold_n && growth_q > growth_cur) ?
                        growth_q : growth_cur;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            growth_q <= GROWTH_RST;
        end else if (adv) begin
            growth_q <= growth_d;
        end
    end

    // Unsigned view flips only the sign bit
    assign push_data = '{real_out: {sel_real[OUT_W-1] ^ !pin_s2_q.fmt, sel_real[OUT_W-2:0]},
                         imag_out: {sel_imag[OUT_W-1] ^ !pin_s2_q.fmt, sel_imag[OUT_W-2:0]},
                         growth:   growth_d};

    // =====================================================================
    // Output FIFO and output register
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    cmr_sample_t fifo_out_data;
    cmr_sample_t out_q;
    logic        out_valid_q;
    logic        stall_q;

    assign adv            = fifo_in_ready;
    assign fifo_out_ready = !out_valid_q || i_out_ready;

    cmr_fifo #(
        .WIDTH ($bits(cmr_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_valid   (run_q),
        .o_ready   (fifo_in_ready),
        .i_data    (push_data),
        .o_valid   (fifo_out_valid),
        .i_ready   (fifo_out_ready),
        .o_data    (fifo_out_data)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            run_q       <= 1'b0;
            stall_q     <= 1'b0;
            out_valid_q <= 1'b0;
            out_q       <= '0;
        end else begin
            run_q   <= 1'b1;
            stall_q <= !fifo_in_ready;
            if (fifo_out_ready) begin
                out_valid_q <= fifo_out_valid;
                if (fifo_out_valid) out_q <= fifo_out_data;
            end
        end
    end

    assign o_real_out     = out_q.real_out;
    assign o_imag_out     = out_q.imag_out;
    assign o_growth_code  = out_q.growth;
    assign o_out_valid    = out_valid_q;
    assign o_sample_stall = stall_q;

    // =====================================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_round_load: assert property (round_load |=> round_word_q == $past(pin_s2_q.cfg_word))
        else $error("rounding word not loaded");
    a_round_ignore: assert property (!round_load |=> $stable(round_word_q))
        else $error("rounding word changed without a load");
    a_in_capture: assert property ((adv && !pin_s2_q.in_en_n) |=>
                                   in_real_q == $past(pin_s2_q.real_in))
        else $error("input word not captured");
    a_in_hold: assert property ((!adv || pin_s2_q.in_en_n) |=> $stable(in_imag_q))
        else $error("input word changed while disabled");
    a_mult_real: assert property (adv |=> mult_real_q ==
                                  cmul($past(i_cos), $past(sc_real), $past(i_sin),
                                       $past(sc_imag), 1'b1))
        else $error("real product wrong");
    a_acc_keep: assert property ((adv && !pin_s2_q.feedback_keep) |=>
                                 acc_imag_q[MULT_W-1:0] == $past(mult_imag_q))
        else $error("accumulator feedback not cleared");
    a_cacc_sum: assert property ((adv && pin_s2_q.feedback_keep) |=>
                                 cacc_real_q == $past(cacc_real_q)
                                 + {{(CACC_W-DATA_W){$past(sc_real[DATA_W-1])}},
                                    $past(sc_real)})
        else $error("complex accumulator sum wrong");
    a_fmt_sign: assert property (push_data.real_out[OUT_W-1] ==
                                 (sel_real[OUT_W-1] ^ !pin_s2_q.fmt))
        else $error("format sign bit wrong");
    a_round_off: assert property ((pin_s2_q.round_enable_n && pin_s2_q.src_sel == SRC_PROD)
                                  |-> sel_real == acc_real_q[PROD_OUT_LSB +: OUT_W])
        else $error("output rounded while disabled");
    a_peak_hold: assert property ((adv && !pin_s2_q.peak_hold_n) |=>
                                  growth_q >= $past(growth_q))
        else $error("peak growth dropped");

    c_round_write:  cover property (round_load ##1 round_word_q != ROUND_WORD_RST);
    c_fifo_full:    cover property (!fifo_in_ready ##[1:20] fifo_in_ready);
    c_cacc_out:     cover property (pin_s2_q.src_sel == SRC_CACC && o_out_valid);
    c_growth_three: cover property (growth_q == 2'h3);
endmodule // cmr_top

// ### tb/cmr_src_model.sv
module cmr_src_model import cmr_pkg::*; (
    input  wire logic         i_clk_sys,
    output logic [DATA_W-1:0] o_real_in,
    output logic [DATA_W-1:0] o_imag_in,
    output logic [DATA_W-1:0] o_cos,
    output logic [DATA_W-1:0] o_sin,
    output logic              o_en_n,
    output logic [WORD_W-1:0] o_cfg,
    output logic [1:0]        o_tgt,
    output logic              o_cs_n,
    output logic              o_wr_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Sample source
    initial begin
        o_en_n = 1'b0;
        o_cfg = 16'h0000;
        o_tgt = 2'h0;
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
    end
    task automatic put(input logic [15:0] r, i, c, s, input logic en_n);
        @(negedge i_clk_sys);
        o_real_in = r;
        o_imag_in = i;
        o_cos = c;
        o_sin = s;
        o_en_n = en_n;
    endtask
    // ==========
    // Host write port
    // Released bus shows inverted data so a stale word is never read as valid
    task automatic load_word(input logic [15:0] w, input logic [1:0] t, input logic cs_n);
        @(negedge i_clk_sys);
        o_cfg = w;
        o_tgt = t;
        o_cs_n = cs_n;
        o_wr_n = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        o_wr_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        o_cfg = ~w;
        o_tgt = ~t;
        o_cs_n = 1'b1;
        repeat (2) @(negedge i_clk_sys);
    endtask
endmodule // cmr_src_model

// ### tb/test_complex_mac_output_round.sv
module test_complex_mac_output_round import cmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Stimulus, shadows and results
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  sh = 2'h0;
    logic [1:0]  src = 2'h0;
    logic        keep = 1'b0, fmt = 1'b1, pk_n = 1'b1, rn_n = 1'b1, rdy = 1'b1;
    logic [15:0] rw = 16'h0000;
    logic [15:0] s_re, s_im, s_c, s_s, re, im, cs, sn, cfg;
    logic [1:0]  tgt, gc;
    logic        en_n, cs_n, wr_n, ov, st;
    logic [19:0] ro, io;
    logic [63:0] vt [3] = '{64'h8000_8000_8000_8000, 64'h7FFF_8001_5A82_A57E,
                            64'h4321_FEDC_0001_7FFF};
    int          bad_count = 0;
    int          cmp_count = 0;

    cmr_top i_cmr_top (.i_clk_sys(clk_sys), .i_rst(rst), .i_real_in(re), .i_imag_in(im),
        .i_input_reg_clock_en_n(en_n), .i_input_scale_select(sh), .i_feedback_keep(keep),
        .i_output_source_select(src), .i_output_number_format(fmt), .i_peak_hold_n(pk_n),
        .i_round_enable_n(rn_n), .i_config_word_bus(cfg), .i_load_target_select(tgt),
        .i_chip_select_n(cs_n), .i_write_n(wr_n), .i_cos(cs), .i_sin(sn), .i_out_ready(rdy),
        .o_real_out(ro), .o_imag_out(io), .o_growth_code(gc), .o_out_valid(ov),
        .o_sample_stall(st));
    cmr_src_model i_cmr_src_model (.i_clk_sys(clk_sys), .o_real_in(re), .o_imag_in(im),
        .o_cos(cs), .o_sin(sn), .o_en_n(en_n), .o_cfg(cfg), .o_tgt(tgt), .o_cs_n(cs_n),
        .o_wr_n(wr_n));

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // ==========
    // Reference and compares
    task automatic cmp_out(input string nm, input logic [19:0] e, input logic [19:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [19:0] pick(input logic [34:0] v, input int lo, input logic [3:0] k);
        logic [34:0] t;
        logic        on;
        on = !rn_n && k >= 4'h1 && k <= 4'hC;
        t = v;
        if (on && lo + k >= 2) t = v + (35'h1 << (lo + k - 2));
        return on ? (t[lo +: 20] & ~((20'h1 << (k - 1)) - 20'h1)) : t[lo +: 20];
    endfunction
    function automatic logic [1:0] grw(input logic [19:0] v);
        if (v[19:16] == {4{v[19]}}) return 2'h0;
        if (v[19:17] == {3{v[19]}}) return 2'h1;
        return (v[19] == v[18]) ? 2'h2 : 2'h3;
    endfunction
    function automatic logic [19:0] sel(input logic [15:0] a, b, input logic neg);
        logic [34:0] p;
        logic [34:0] q;
        logic [15:0] sa;
        logic [15:0] sb;
        // Scale select is an arithmetic right shift of each input
        sa = 16'($signed(a) >>> sh);
        sb = 16'($signed(b) >>> sh);
        q = 35'($signed(s_s)) * 35'($signed(sb));
        p = 35'($signed(s_c)) * 35'($signed(sa)) + (neg ? -q : q);
        case (src)
            2'h0: return pick(p, 15, rw[7:4]);
            2'h1: return {p[34:31], 1'b0, p[14:0]};
            2'h2: return pick(35'($signed(sa)), 0, rw[3:0]);
            default: return 20'h00000;
        endcase
    endfunction
    task automatic check(input string nm);
        logic [19:0] er;
        logic [19:0] ei;
        logic [1:0]  eg;
        er = sel(s_re, s_im, 1'b1);
        ei = sel(s_im, s_re, 1'b0);
        eg = (grw(er) > grw(ei)) ? grw(er) : grw(ei);
        er[19] ^= !fmt;
        ei[19] ^= !fmt;
        cmp_out({nm, " real"}, er, ro);
        cmp_out({nm, " imag"}, ei, io);
        cmp_out({nm, " growth"}, 20'(eg), 20'(gc));
    endtask
    task automatic drive(input logic [15:0] a, b, c, d);
        s_re = a;
        s_im = b;
        s_c = c;
        s_s = d;
        i_cmr_src_model.put(a, b, c, d, 1'b0);
    endtask
    task automatic settle();
        repeat (12) @(negedge clk_sys);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Whole run is about 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("ERROR watchdog expected finish seen hang");
        final_report();
    end
    // ==========
    // Tests
    initial begin
        logic [19:0] a;
        logic [19:0] b;
        repeat (2) @(negedge clk_sys);
        cmp_out("reset valid", 20'h00000, 20'(ov));
        rst = 1'b0;
        rn_n = 1'b0;
        drive(16'h1235, 16'hEDCB, 16'h7FFF, 16'h0123);
        settle();
        check("round word reset");
        rn_n = 1'b1;
        $display("test reset done");
        for (int v = 0; v < 3; v++) begin
            drive(vt[v][63:48], vt[v][47:32], vt[v][31:16], vt[v][15:0]);
            for (int m = 0; m < 32; m++) begin
                sh = m[1:0];
                src = m[3:2];
                fmt = m[4];
                settle();
                check("sweep");
            end
        end
        $display("test sweep done");
        rn_n = 1'b0;
        sh = 2'h1;
        drive(16'h1235, 16'hEDCB, 16'h7FFF, 16'h0123);
        for (int k = 0; k < 16; k++) begin
            rw = {8'hA5, k[3:0], ~k[3:0]};
            i_cmr_src_model.load_word(rw, 2'h3, 1'b0);
            src = 2'h0;
            settle();
            check("round product");
            src = 2'h2;
            settle();
            check("round acc");
        end
        rw = 16'h0033;
        i_cmr_src_model.load_word(rw, 2'h3, 1'b0);
        i_cmr_src_model.load_word(16'h00CC, 2'h3, 1'b1);
        i_cmr_src_model.load_word(16'h00CC, 2'h2, 1'b0);
        settle();
        check("ignored write");
        rn_n = 1'b1;
        settle();
        check("round disabled");
        $display("test rounding done");
        src = 2'h0;
        drive(16'h0100, 16'h0000, 16'h4000, 16'h0000);
        settle();
        i_cmr_src_model.put(16'h7FFF, 16'h0000, 16'h4000, 16'h0000, 1'b1);
        keep = 1'b1;
        settle();
        a = ro;
        @(negedge clk_sys);
        b = ro;
        cmp_out("product step", 20'h00040, b - a);
        src = 2'h2;
        settle();
        a = ro;
        @(negedge clk_sys);
        b = ro;
        cmp_out("acc step", 20'h00080, b - a);
        keep = 1'b0;
        settle();
        check("input hold");
        pk_n = 1'b0;
        sh = 2'h0;
        drive(16'h4000, 16'h0000, 16'h4000, 16'h0000);
        settle();
        keep = 1'b1;
        repeat (24) @(negedge clk_sys);
        keep = 1'b0;
        settle();
        cmp_out("peak growth", 20'h00003, 20'(gc));
        pk_n = 1'b1;
        settle();
        check("peak released");
        $display("test accumulate done");
        rdy = 1'b0;
        repeat (3) @(negedge clk_sys);
        a = ro;
        drive(16'h0777, 16'h8123, 16'h7FFF, 16'h0400);
        repeat (40) @(negedge clk_sys);
        cmp_out("stall flag", 20'h00001, 20'(st));
        cmp_out("held sample", a, ro);
        cmp_out("held valid", 20'h00001, 20'(ov));
        rdy = 1'b1;
        repeat (40) @(negedge clk_sys);
        check("after stall");
        $display("test stall done");
        final_report();
    end
endmodule // test_complex_mac_output_round
